//--- rtl/scn_regs.sv
// Purpose: host register front end: image byte port, status, table data port
// Assumes: Avalon-MM slave with waitrequest, byte address, data in bits 7..0
// Notes: table memories and image buffer sit outside behind simple handshakes
//
// The implementer's own choice: the Avalon-MM register port.
`timescale 1ns/1ns
module scn_regs
  import scn_regs_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  // avalon-mm slave
  input wire logic [6:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // image buffer stream
  input wire logic [7:0] img_data_in,
  input wire logic img_valid_in,
  output logic img_ready_out,
  // status from scan logic
  input wire logic [7:0] buf_count_in,
  input wire logic pause_in,
  // sense pins
  input wire logic sheet_detect_one_in,
  input wire logic sheet_detect_two_in,
  input wire logic [5:0] aux_in,
  // table memory port
  output scn_tbl_cmd_t tbl_cmd_out,
  output logic tbl_req_out,
  input wire logic tbl_ack_in,
  input wire logic [7:0] tbl_rdata_in,
  output logic mem_test_out
);

  typedef enum logic [1:0] {
    SCN_ST_IDLE = 2'b00,
    SCN_ST_IMG = 2'b01,
    SCN_ST_MEM = 2'b10,
    SCN_ST_DONE = 2'b11
  } scn_state_t;

  scn_state_t st_q;
  logic [7:0] rdata_q;
  logic wait_q;
  logic pop_q;
  logic req_q;
  scn_tbl_cmd_t cmd_q;
  logic [7:0] ctrl_q;
  logic [13:0] addr_q;
  logic dir_q;
  logic phase_q;
  logic [7:0] edge_sel_q;
  logic [7:0] pin_state;

  // bus decode
  wire [4:0] idx = avs_address_in[6:2];
  wire idle = (st_q == SCN_ST_IDLE);
  wire wr_ok = idle && avs_write_in && avs_byteenable_in[0];
  wire rd_req = idle && avs_read_in;
  wire wr_ctrl = wr_ok && (idx == SCN_IDX_CTRL);
  wire wr_ahi = wr_ok && (idx == SCN_IDX_ADDR_HI);
  wire wr_alo = wr_ok && (idx == SCN_IDX_ADDR_LO);
  wire wr_edge = wr_ok && (idx == SCN_IDX_EDGE_SEL);
  wire rd_img = rd_req && (idx == SCN_IDX_IMAGE);
  wire rd_pins = rd_req && (idx == SCN_IDX_PINS);
  wire mem_rd = rd_req && (idx == SCN_IDX_DATA) && dir_q;
  wire mem_wr = wr_ok && (idx == SCN_IDX_DATA) && !dir_q;
  wire mem_done = (st_q == SCN_ST_MEM) && tbl_ack_in;
  wire is_gamma = (ctrl_q[SCN_CTRL_TGT_LSB +: 2] == SCN_TGT_GAMMA);
  wire entry_end = is_gamma || phase_q;

  // read multiplexer; unmapped and wrong-direction reads give zero
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    case (idx)
      SCN_IDX_AMOUNT: rd_mux = buf_count_in;
      SCN_IDX_PINS: rd_mux = pin_state;
      SCN_IDX_CTRL: rd_mux = {1'b0, ctrl_q[SCN_CTRL_TEST_BIT], 1'b0, pause_in, ctrl_q[3:0]};
      SCN_IDX_ADDR_HI: rd_mux = {1'b0, dir_q, addr_q[13:8]};
      SCN_IDX_ADDR_LO: rd_mux = addr_q[7:0];
      SCN_IDX_EDGE_SEL: rd_mux = edge_sel_q;
      default: rd_mux = 8'h00;
    endcase
  end

  // pins are synchronised inside; the read pulse clears edge bits
  scn_pin_capture #(
    .W(8)
  ) u_pins (
    .sys_clk_in(sys_clk_in),
    .reset_n_in(reset_n_in),
    .pins_in({aux_in, sheet_detect_two_in, sheet_detect_one_in}),
    .edge_sel_in(edge_sel_q),
    .clear_in(rd_pins),
    .state_out(pin_state)
  );

  // control register; pause bit is never stored, it reads live
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      ctrl_q <= SCN_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_q <= {1'b0, avs_writedata_in[SCN_CTRL_TEST_BIT], 2'b00, avs_writedata_in[3:0]};
    end
  end

  assign mem_test_out = ctrl_q[SCN_CTRL_TEST_BIT];

  // edge sensitivity select, one bit per pin
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      edge_sel_q <= SCN_EDGE_SEL_RST;
    end else if (wr_edge) begin
      edge_sel_q <= avs_writedata_in[7:0];
    end
  end

  // address, direction and byte phase; advance after each whole entry
  logic [13:0] addr_d;
  logic phase_d;
  always_comb begin
    addr_d = addr_q;
    phase_d = phase_q;
    if (wr_ahi) begin
      addr_d = {avs_writedata_in[SCN_AHI_ADDR_W-1:0], addr_q[7:0]};
      phase_d = 1'b0;
    end else if (wr_alo) begin
      addr_d = {addr_q[13:8], avs_writedata_in[7:0]};
      phase_d = 1'b0;
    end else if (mem_done) begin
      addr_d = entry_end ? addr_q + 14'h0001 : addr_q;
      phase_d = entry_end ? 1'b0 : 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      addr_q <= SCN_ADDR_RST;
      dir_q <= SCN_DIR_RST;
      phase_q <= 1'b0;
    end else begin
      addr_q <= addr_d;
      phase_q <= phase_d;
      if (wr_ahi) begin
        dir_q <= avs_writedata_in[SCN_AHI_DIR_BIT];
      end
    end
  end

  // access sequencer; waitrequest drops for exactly the answer cycle
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      st_q <= SCN_ST_IDLE;
      wait_q <= 1'b1;
      rdata_q <= 8'h00;
      pop_q <= 1'b0;
      req_q <= 1'b0;
      cmd_q <= '0;
    end else begin
      pop_q <= 1'b0;
      case (st_q)
        SCN_ST_IDLE: begin
          if (rd_img) begin
            st_q <= SCN_ST_IMG;
          end else if (mem_rd || mem_wr) begin
            req_q <= 1'b1;
            cmd_q <= '{we: mem_wr, target: scn_target_t'(ctrl_q[1:0]), color: scn_color_t'(ctrl_q[3:2]),
                       addr: addr_q, hi_byte: phase_q, wdata: avs_writedata_in[7:0]};
            st_q <= SCN_ST_MEM;
          end else if (avs_read_in || avs_write_in) begin
            rdata_q <= avs_read_in ? rd_mux : 8'h00;
            wait_q <= 1'b0;
            st_q <= SCN_ST_DONE;
          end
        end
        SCN_ST_IMG: begin
          // stall the bus until the buffer really has a byte
          if (img_valid_in) begin
            rdata_q <= img_data_in;
            pop_q <= 1'b1;
            wait_q <= 1'b0;
            st_q <= SCN_ST_DONE;
          end
        end
        SCN_ST_MEM: begin
          if (tbl_ack_in) begin
            req_q <= 1'b0;
            rdata_q <= cmd_q.we ? 8'h00 : tbl_rdata_in;
            wait_q <= 1'b0;
            st_q <= SCN_ST_DONE;
          end
        end
        SCN_ST_DONE: begin
          wait_q <= 1'b1;
          st_q <= SCN_ST_IDLE;
        end
        default: begin
          st_q <= SCN_ST_IDLE;
          wait_q <= 1'b1;
        end
      endcase
    end
  end

  assign avs_readdata_out = {24'h000000, rdata_q};
  assign avs_waitrequest_out = wait_q;
  assign img_ready_out = pop_q;
  assign tbl_req_out = req_q;
  assign tbl_cmd_out = cmd_q;

  // checks
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);

  property p_img_pop;
    img_ready_out |-> !avs_waitrequest_out && avs_readdata_out[7:0] == $past(img_data_in) && $past(img_valid_in);
  endproperty
  a_img_pop: assert property (p_img_pop) else $error("image byte not returned with pop");

  property p_amount;
    (rd_req && idx == SCN_IDX_AMOUNT) |=> !avs_waitrequest_out && avs_readdata_out[7:0] == $past(buf_count_in);
  endproperty
  a_amount: assert property (p_amount) else $error("amount read wrong");

  property p_pins;
    rd_pins |=> avs_readdata_out[7:0] == $past(pin_state) ##1 avs_waitrequest_out;
  endproperty
  a_pins: assert property (p_pins) else $error("pin state read wrong");

  property p_pause;
    (rd_req && idx == SCN_IDX_CTRL) |=> avs_readdata_out[SCN_CTRL_PAUSE_BIT] == $past(pause_in);
  endproperty
  a_pause: assert property (p_pause) else $error("pause flag wrong");

  property p_addr_lo;
    wr_alo |=> addr_q[7:0] == $past(avs_writedata_in[7:0]) && addr_q[13:8] == $past(addr_q[13:8]);
  endproperty
  a_addr_lo: assert property (p_addr_lo) else $error("low address not loaded");

  property p_dir;
    $rose(tbl_req_out) |-> tbl_cmd_out.we == !dir_q;
  endproperty
  a_dir: assert property (p_dir) else $error("access direction wrong");

  property p_target;
    tbl_req_out |-> tbl_cmd_out.target == ctrl_q[1:0] && tbl_cmd_out.color == ctrl_q[3:2] &&
                    tbl_cmd_out.addr == addr_q;
  endproperty
  a_target: assert property (p_target) else $error("access target wrong");

  property p_entry;
    (mem_done && !is_gamma && !phase_q) |=> phase_q && addr_q == $past(addr_q);
  endproperty
  a_entry: assert property (p_entry) else $error("coefficient first byte advanced");

  property p_gamma_step;
    (mem_done && is_gamma && !wr_ahi && !wr_alo) |=> addr_q == $past(addr_q) + 14'h0001;
  endproperty
  a_gamma_step: assert property (p_gamma_step) else $error("gamma address not stepped");

  property p_test;
    wr_ctrl |=> mem_test_out == $past(avs_writedata_in[SCN_CTRL_TEST_BIT]);
  endproperty
  a_test: assert property (p_test) else $error("test mode not set");

  property p_wait_pulse;
    !avs_waitrequest_out |=> avs_waitrequest_out;
  endproperty
  a_wait_pulse: assert property (p_wait_pulse) else $error("waitrequest low too long");

  property p_rst;
    $rose(reset_n_in) |-> ctrl_q == SCN_CTRL_RST && addr_q == SCN_ADDR_RST && avs_waitrequest_out;
  endproperty
  a_rst: assert property (@(posedge sys_clk_in) p_rst) else $error("reset defaults missing");

  // a high-address write also restarts the byte phase, so a half entry never leaks into the new address
  property p_addr_hi;
    wr_ahi |=> addr_q[13:8] == $past(avs_writedata_in[5:0]) && !phase_q &&
               dir_q == $past(avs_writedata_in[SCN_AHI_DIR_BIT]);
  endproperty
  a_addr_hi: assert property (p_addr_hi) else $error("high address or direction not loaded");

  property p_no_access;
    (idle && (avs_read_in || avs_write_in) && idx == SCN_IDX_DATA && !mem_rd && !mem_wr) |=> !tbl_req_out;
  endproperty
  a_no_access: assert property (p_no_access) else $error("wrong-direction access reached table");

  property p_ctrl_store;
    wr_ctrl |=> ctrl_q[3:0] == $past(avs_writedata_in[3:0]);
  endproperty
  a_ctrl_store: assert property (p_ctrl_store) else $error("target or color not stored");

  property p_coef_step;
    (mem_done && !is_gamma && phase_q) |=> !phase_q && addr_q == $past(addr_q) + 14'h0001;
  endproperty
  a_coef_step: assert property (p_coef_step) else $error("coefficient entry not stepped");

  // after a read only a fresh edge may leave an edge-sensitive bit set
  property p_pin_clear;
    rd_pins |=> (pin_state & $past(edge_sel_q) & ~$past(u_pins.rise)) == 8'h00;
  endproperty
  a_pin_clear: assert property (p_pin_clear) else $error("edge bit not cleared by read");

  property p_img_wait;
    (st_q == SCN_ST_IMG && !img_valid_in) |=> avs_waitrequest_out && !img_ready_out;
  endproperty
  a_img_wait: assert property (p_img_wait) else $error("image read answered without a byte");

  property p_cv_img;
    rd_img ##[1:20] img_ready_out;
  endproperty
  c_cv_img: cover property (p_cv_img);

  property p_cv_mem_wr;
    mem_wr ##[1:20] mem_done;
  endproperty
  c_cv_mem_wr: cover property (p_cv_mem_wr);

  property p_cv_mem_rd;
    mem_rd ##[1:20] mem_done;
  endproperty
  c_cv_mem_rd: cover property (p_cv_mem_rd);

  property p_cv_pins;
    rd_pins && (pin_state & edge_sel_q) != 8'h00;
  endproperty
  c_cv_pins: cover property (p_cv_pins);

endmodule

//--- rtl/scn_regs_pkg.sv
// Purpose: shared constants and types of the scanner register front end
// Assumes: one 50 MHz system clock, synchronous active-low reset
// Notes: register index times four is the byte address on the bus
package scn_regs_pkg;

  // register indices
  localparam logic [4:0] SCN_IDX_IMAGE = 5'h00;
  localparam logic [4:0] SCN_IDX_AMOUNT = 5'h01;
  localparam logic [4:0] SCN_IDX_PINS = 5'h02;
  localparam logic [4:0] SCN_IDX_CTRL = 5'h03;
  localparam logic [4:0] SCN_IDX_ADDR_HI = 5'h04;
  localparam logic [4:0] SCN_IDX_ADDR_LO = 5'h05;
  localparam logic [4:0] SCN_IDX_DATA = 5'h06;
  localparam logic [4:0] SCN_IDX_EDGE_SEL = 5'h10;

  // table_port_control field positions
  localparam int SCN_CTRL_TGT_LSB = 0;
  localparam int SCN_CTRL_COLOR_LSB = 2;
  localparam int SCN_CTRL_PAUSE_BIT = 4;
  localparam int SCN_CTRL_TEST_BIT = 6;
  // table_address_high field positions
  localparam int SCN_AHI_DIR_BIT = 6;
  localparam int SCN_AHI_ADDR_W = 6;

  // reset values
  localparam logic [7:0] SCN_CTRL_RST = 8'h00;
  localparam logic [13:0] SCN_ADDR_RST = 14'h0000;
  localparam logic SCN_DIR_RST = 1'b0;
  localparam logic [7:0] SCN_EDGE_SEL_RST = 8'h00;

  // highest legal entry addresses per target
  localparam logic [13:0] SCN_GAMMA_MAX = 14'h0FFF;
  localparam logic [13:0] SCN_COEF_MAX = 14'h3FFF;

  typedef enum logic [1:0] {
    SCN_TGT_OFFSET = 2'b00,
    SCN_TGT_GAIN = 2'b01,
    SCN_TGT_GAMMA = 2'b10,
    SCN_TGT_NONE = 2'b11
  } scn_target_t;

  typedef enum logic [1:0] {
    SCN_COL_RED = 2'b00,
    SCN_COL_GREEN = 2'b01,
    SCN_COL_BLUE = 2'b10,
    SCN_COL_NONE = 2'b11
  } scn_color_t;

  // one byte access to a coefficient or gamma memory
  typedef struct packed {
    logic we;
    scn_target_t target;
    scn_color_t color;
    logic [13:0] addr;
    logic hi_byte;
    logic [7:0] wdata;
  } scn_tbl_cmd_t;

endpackage

//--- rtl/scn_pin_capture.sv
// Purpose: synchronise sense pins and hold level or sticky edge state
// Assumes: pins are asynchronous to sys_clk_in
// Notes: an edge arriving with the clear pulse survives the clear
`timescale 1ns/1ns
module scn_pin_capture #(
  parameter int W = 8
) (
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic [W-1:0] pins_in,
  input wire logic [W-1:0] edge_sel_in,
  input wire logic clear_in,
  output logic [W-1:0] state_out
);

  logic [W-1:0] sync1_q;
  logic [W-1:0] sync2_q;
  logic [W-1:0] prev_q;
  logic [W-1:0] rise;
  logic [W-1:0] state_d;

  // two-stage synchroniser, first stage read only by the second
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      sync1_q <= '0;
      sync2_q <= '0;
      prev_q <= '0;
    end else begin
      sync1_q <= pins_in;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end

  // edge bits latch a rising edge until read; level bits follow the pin
  assign rise = sync2_q & ~prev_q;
  assign state_d = (edge_sel_in & (rise | (state_out & {W{~clear_in}}))) | (~edge_sel_in & sync2_q);

  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      state_out <= '0;
    end else begin
      state_out <= state_d;
    end
  end

endmodule

//--- bench/scn_regs_tb.sv
// Purpose: self-checking bench for the scanner register front end
// Assumes: avalon slave answers by waitrequest low; table memory and image buffer are bench responders
// Notes: table memory returns low address byte plus byte phase, so every read value is predictable
`timescale 1ns/1ns
module scn_regs_tb;
  import scn_regs_pkg::*;
  typedef struct {logic [6:0] a; bit w; logic [7:0] d; logic [7:0] e;} scn_row_t;
  logic sys_clk_in, reset_n_in, rd, wr, img_valid, pause, sd1, sd2, tbl_ack, mem_test, tbl_req, img_ready, waitreq;
  logic [6:0] addr;
  logic [31:0] wdata, rdata, q;
  logic [3:0] be;
  logic [7:0] img_data, buf_count, tbl_rdata;
  logic [5:0] aux;
  scn_tbl_cmd_t tbl_cmd, last_cmd;
  int n_errors, n_checks, n_tbl;
  scn_row_t rows[14] = '{'{7'h0C, 0, 8'h00, 8'h10}, '{7'h10, 0, 8'h00, 8'h00}, '{7'h14, 0, 8'h00, 8'h00},
    '{7'h40, 0, 8'h00, 8'h00}, '{7'h04, 0, 8'h00, 8'hC3}, '{7'h04, 1, 8'h33, 8'h00}, '{7'h04, 0, 8'h00, 8'hC3},
    '{7'h1C, 0, 8'h00, 8'h00}, '{7'h0C, 1, 8'hFF, 8'h00}, '{7'h0C, 0, 8'h00, 8'h5F}, '{7'h10, 1, 8'hFF, 8'h00},
    '{7'h10, 0, 8'h00, 8'h7F}, '{7'h14, 1, 8'hA5, 8'h00}, '{7'h14, 0, 8'h00, 8'hA5}};

  scn_regs dut_u (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .avs_address_in(addr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(wdata), .avs_byteenable_in(be), .avs_readdata_out(rdata),
    .avs_waitrequest_out(waitreq), .img_data_in(img_data), .img_valid_in(img_valid), .img_ready_out(img_ready),
    .buf_count_in(buf_count), .pause_in(pause), .sheet_detect_one_in(sd1), .sheet_detect_two_in(sd2),
    .aux_in(aux), .tbl_cmd_out(tbl_cmd), .tbl_req_out(tbl_req), .tbl_ack_in(tbl_ack), .tbl_rdata_in(tbl_rdata),
    .mem_test_out(mem_test));

  // 50 MHz clock
  initial begin
    sys_clk_in = 1'b0;
    forever #10 sys_clk_in = ~sys_clk_in;
  end

  // table memory: ack one cycle after request, read byte derived from address and phase
  always @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      tbl_ack <= 1'b0;
      tbl_rdata <= 8'h00;
      img_data <= 8'h11;
      n_tbl <= 0;
    end else begin
      tbl_ack <= tbl_req && !tbl_ack;
      tbl_rdata <= tbl_cmd.addr[7:0] + {7'h00, tbl_cmd.hi_byte};
      if (tbl_req && tbl_ack) begin
        last_cmd <= tbl_cmd;
        n_tbl <= n_tbl + 1;
      end
      // buffer advances only on a pop, so the byte holds while the bus waits
      if (img_ready) img_data <= img_data + 8'h01;
    end
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      n_errors++;
      $display("BAD at %0t seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // one avalon access; request held until waitrequest is sampled low
  task automatic bus(input logic [6:0] a, input bit w, input logic [7:0] d, output logic [31:0] r);
    @(posedge sys_clk_in);
    addr <= a;
    rd <= !w;
    wr <= w;
    wdata <= {24'h000000, d};
    // only the watchdog ends a wait that never gets an answer
    do begin
      @(posedge sys_clk_in);
    end while (waitreq !== 1'b0);
    r = rdata;
    chk(rdata[31:8], 24'h000000);
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic rchk(input logic [6:0] a, input logic [7:0] e);
    bus(a, 0, 8'h00, q);
    chk(q, {24'h0, e});
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk_in);
    n_errors++;
    stop_test();
  end

  initial begin
    {rd, wr, img_valid, sd1, sd2, addr, wdata, aux} = '0;
    reset_n_in = 1'b0;
    be = 4'hF;
    buf_count = 8'hC3;
    pause = 1'b1;
    repeat (20) @(posedge sys_clk_in);
    chk({waitreq, mem_test, tbl_req, img_ready}, 4'b1000);
    reset_n_in <= 1'b1;
    // plain register rows: defaults, read-only, unmapped, readback
    foreach (rows[i]) begin
      bus(rows[i].a, rows[i].w, rows[i].d, q);
      if (!rows[i].w) chk(q, {24'h0, rows[i].e});
    end
    chk(mem_test, 1'b1);
    bus(7'h0C, 1, 8'h00, q);
    pause <= 1'b0;
    chk(mem_test, 1'b0);
    rchk(7'h0C, 8'h00);
    $display("register rows done");
    // image read stalls until the buffer has a byte, then back to back
    fork
      bus(7'h00, 0, 8'h00, q);
      begin
        repeat (6) @(posedge sys_clk_in);
        img_valid <= 1'b1;
      end
    join
    chk(q, 32'h11);
    rchk(7'h00, 8'h12);
    $display("image read done");
    // level pins then a sticky edge bit cleared by reading
    sd1 <= 1'b1;
    sd2 <= 1'b1;
    aux <= 6'b101010;
    repeat (5) @(posedge sys_clk_in);
    rchk(7'h08, 8'hAB);
    // pins go low before edge mode, so no level state is left behind as a false edge
    sd1 <= 1'b0;
    sd2 <= 1'b0;
    aux <= 6'b000000;
    repeat (5) @(posedge sys_clk_in);
    bus(7'h40, 1, 8'h01, q);
    sd1 <= 1'b1;
    repeat (5) @(posedge sys_clk_in);
    sd1 <= 1'b0;
    repeat (5) @(posedge sys_clk_in);
    rchk(7'h08, 8'h01);
    rchk(7'h08, 8'h00);
    $display("pin status done");
    // every target and color code reaches the table port
    for (int i = 0; i < 16; i++) begin
      bus(7'h0C, 1, i[7:0], q);
      bus(7'h10, 1, 8'h00, q);
      bus(7'h14, 1, 8'h00, q);
      bus(7'h18, 1, 8'h3C, q);
      chk({last_cmd.target, last_cmd.color}, {i[1:0], i[3:2]});
    end
    // gamma writes at the top of the range, one byte per entry
    bus(7'h0C, 1, 8'h0A, q);
    bus(7'h10, 1, 8'h0F, q);
    bus(7'h14, 1, 8'hFE, q);
    bus(7'h18, 1, 8'h77, q);
    chk(last_cmd, {1'b1, SCN_TGT_GAMMA, SCN_COL_BLUE, 14'h0FFE, 1'b0, 8'h77});
    bus(7'h18, 1, 8'h78, q);
    chk(last_cmd, {1'b1, SCN_TGT_GAMMA, SCN_COL_BLUE, SCN_GAMMA_MAX, 1'b0, 8'h78});
    rchk(7'h18, 8'h00);
    $display("gamma writes done");
    // gain reads at the top of the range, two bytes per entry
    bus(7'h0C, 1, 8'h05, q);
    bus(7'h10, 1, 8'h7F, q);
    bus(7'h14, 1, 8'hFE, q);
    rchk(7'h18, 8'hFE);
    chk({last_cmd.we, last_cmd.addr, last_cmd.hi_byte}, {1'b0, 14'h3FFE, 1'b0});
    rchk(7'h18, 8'hFF);
    chk({last_cmd.target, last_cmd.color, last_cmd.hi_byte}, {SCN_TGT_GAIN, SCN_COL_GREEN, 1'b1});
    rchk(7'h18, 8'hFF);
    chk({last_cmd.addr, last_cmd.hi_byte}, {SCN_COEF_MAX, 1'b0});
    // a write while read direction is set must not reach the table
    bus(7'h18, 1, 8'h55, q);
    repeat (3) @(posedge sys_clk_in);
    chk(n_tbl, 16 + 2 + 3);
    // a write without its low byte enable is answered but ignored
    be <= 4'hE;
    bus(7'h14, 1, 8'h00, q);
    be <= 4'hF;
    rchk(7'h14, 8'hFF);
    $display("coefficient reads done");
    // mid-run reset restores every default, test mode included
    bus(7'h0C, 1, 8'h4A, q);
    reset_n_in <= 1'b0;
    repeat (3) @(posedge sys_clk_in);
    chk({waitreq, mem_test, tbl_req, img_ready}, 4'b1000);
    reset_n_in <= 1'b1;
    rchk(7'h10, 8'h00);
    rchk(7'h40, 8'h00);
    rchk(7'h0C, 8'h00);
    $display("reset defaults done");
    stop_test();
  end
endmodule
